// File: ast_pkg.sv
package ast_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_DATA_BUFFER = 8'hF0;
    localparam logic [7:0] ADDR_PORT3_MODE  = 8'hF7;
    localparam logic [7:0] ADDR_PORT3_PINS  = 8'hF8;
    localparam logic [7:0] ADDR_REQUESTS    = 8'hF9;
    // Mode register bit positions
    localparam int unsigned MODE_PARITY_BIT = 7;
    localparam int unsigned MODE_SERIAL_BIT = 6;
    // Request register bit positions
    localparam int unsigned REQ_RX_BIT = 0;
    localparam int unsigned REQ_TX_BIT = 1;
    // Reset values
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [7:0] SHIFT_ONES   = 8'hFF;
    localparam logic [7:0] DATA_RESET   = 8'h00;
    // Bit timing in timer pulses
    localparam logic [3:0] TICK_ZERO    = 4'h0;
    localparam logic [3:0] TICK_ONE     = 4'h1;
    localparam logic [3:0] TICK_MID     = 4'h8;
    localparam logic [3:0] TICK_LAST    = 4'hF;
    // Frame lengths
    localparam logic [3:0] RX_DATA_BITS = 4'h8;
    localparam logic [3:0] TX_FRAME_BITS = 4'hB;
    localparam logic [3:0] CNT_ZERO     = 4'h0;
    localparam logic [3:0] CNT_ONE      = 4'h1;
    localparam int unsigned DATA_MSB    = 7;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10
    } ast_rx_state_type;

    typedef struct packed {
        logic [7:0]       mode;
        logic             sync1;
        logic             sync2;
        logic             sync_prev;
        ast_rx_state_type rx_state;
        logic [3:0]       rx_tick;
        logic [3:0]       rx_cnt;
        logic [7:0]       rx_shift;
        logic [7:0]       rx_buf;
        logic             rx_req;
        logic             tx_busy;
        logic [3:0]       tx_tick;
        logic [3:0]       tx_cnt;
        logic [10:0]      tx_shift;
        logic             tx_line;
        logic             tx_req;
        logic             timer_irq;
        logic [7:0]       rdata;
    } ast_state_type;
endpackage : ast_pkg

// File: ast_uart.sv
`timescale 1ns/1ns
module ast_uart (
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_timer_tick,
    input  wire logic       i_serial_input_pin,
    output logic            o_serial_out,
    output logic            o_receive_done_request,
    output logic            o_transmit_done_request,
    output logic            o_timer_irq
);
    import ast_pkg::*;

    ast_state_type s_q;
    ast_state_type s_d;
    logic          serial_on;
    logic          parity_on;
    logic          tick;
    logic          wr_data;
    logic [7:0]    tx_char;
    logic [7:0]    rx_char;

    // ==========================================================
    // Decode
    assign serial_on = s_q.mode[MODE_SERIAL_BIT];
    assign parity_on = s_q.mode[MODE_PARITY_BIT];
    // odd parity only, mode bit 7
    assign tick      = serial_on & i_timer_tick;
    assign wr_data   = i_wr && (i_addr == ADDR_DATA_BUFFER);

    always_comb begin
        tx_char = i_wdata;
        if (parity_on) begin
            tx_char[DATA_MSB] = ~(^i_wdata[DATA_MSB-1:0]);
        end
    end

    // receive parity check; rx_char is character after last shift
    always_comb begin
        rx_char = {s_q.sync2, s_q.rx_shift[7:1]};
        if (parity_on) begin
            rx_char[DATA_MSB] = ~(^{s_q.sync2, s_q.rx_shift[7:1]});
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_d           = s_q;
        s_d.timer_irq = 1'b0;
        s_d.sync1     = i_serial_input_pin;
        s_d.sync2     = s_q.sync1;
        s_d.sync_prev = s_q.sync2;
        s_d.rdata     = DATA_RESET;

        // timer interrupt only outside serial mode
        if (!serial_on && i_timer_tick) begin
            s_d.timer_irq = 1'b1;
        end

        // ------ receiver ------
        unique case (s_q.rx_state)
            RX_HUNT: begin
                if (serial_on && s_q.sync_prev && !s_q.sync2) begin
                    s_d.rx_state = RX_START;
                    s_d.rx_tick  = TICK_ZERO;
                end
            end
            RX_START: begin
                if (tick) begin
                    s_d.rx_tick = s_q.rx_tick + TICK_ONE;
                    if (s_q.rx_tick + TICK_ONE == TICK_MID) begin
                        if (s_q.sync2) begin
                            s_d.rx_state = RX_HUNT;
                        end else begin
                            s_d.rx_state = RX_DATA;
                            s_d.rx_tick  = TICK_ZERO;
                            s_d.rx_cnt   = CNT_ZERO;
                        end
                    end
                end
            end
            RX_DATA: begin
                if (tick) begin
                    s_d.rx_tick = s_q.rx_tick + TICK_ONE;
                    if (s_q.rx_tick == TICK_LAST) begin
                        s_d.rx_shift = {s_q.sync2, s_q.rx_shift[7:1]};
                        s_d.rx_cnt   = s_q.rx_cnt + CNT_ONE;
                        // eight data bits, stop not checked
                        if (s_q.rx_cnt + CNT_ONE == RX_DATA_BITS) begin
                            s_d.rx_buf   = rx_char;
                            s_d.rx_req   = 1'b1;
                            s_d.rx_shift = SHIFT_ONES;
                            s_d.rx_state = RX_HUNT;
                        end
                    end
                end
            end
            default: s_d.rx_state = RX_HUNT;
        endcase
        if (!serial_on) begin
            s_d.rx_state = RX_HUNT;
            s_d.rx_shift = SHIFT_ONES;
        end

        // ------ transmitter ------
        if (s_q.tx_busy && tick) begin
            s_d.tx_tick = s_q.tx_tick + TICK_ONE;
            if (s_q.tx_tick == TICK_LAST) begin
                s_d.tx_line  = s_q.tx_shift[0];
                s_d.tx_shift = {1'b1, s_q.tx_shift[10:1]};
                s_d.tx_cnt   = s_q.tx_cnt + CNT_ONE;
                if (s_q.tx_cnt == TX_FRAME_BITS) begin
                    s_d.tx_line = 1'b1;
                    s_d.tx_busy = 1'b0;
                    s_d.tx_req  = 1'b1;
                end
            end
        end
        if (!serial_on) begin
            s_d.tx_busy = 1'b0;
            s_d.tx_line = 1'b1;
        end

        // ------ register bus ------
        if (i_wr) begin
            unique case (i_addr)
                ADDR_PORT3_MODE: s_d.mode = i_wdata;
                ADDR_REQUESTS: begin
                    if (i_wdata[REQ_RX_BIT] && !s_d.rx_req) begin
                        s_d.rx_req = 1'b0;
                    end else if (i_wdata[REQ_RX_BIT] && !s_q.rx_req) begin
                        s_d.rx_req = 1'b1;
                    end else if (i_wdata[REQ_RX_BIT] &&
                                 s_d.rx_req == s_q.rx_req) begin
                        s_d.rx_req = 1'b0;
                    end
                    if (i_wdata[REQ_TX_BIT] && s_d.tx_req == s_q.tx_req) begin
                        s_d.tx_req = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (wr_data && serial_on) begin
            s_d.tx_busy  = 1'b1;
            s_d.tx_tick  = TICK_ZERO;
            s_d.tx_cnt   = CNT_ONE;
            s_d.tx_line  = 1'b0;
            s_d.tx_shift = {2'b11, 1'b1, tx_char};
        end
        if (i_rd) begin
            unique case (i_addr)
                ADDR_DATA_BUFFER: s_d.rdata = s_q.rx_buf;
                ADDR_PORT3_MODE:  s_d.rdata = s_q.mode;
                ADDR_PORT3_PINS:  s_d.rdata = {s_q.tx_line, 6'h00, s_q.sync2};
                ADDR_REQUESTS:    s_d.rdata = {6'h00, s_q.tx_req, s_q.rx_req};
                default:          s_d.rdata = DATA_RESET;
            endcase
        end
    end

    // ==========================================================
    // State register
    // reset disables serial mode and parity
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q           <= '0;
            s_q.mode      <= MODE_RESET;
            s_q.sync1     <= 1'b1;
            s_q.sync2     <= 1'b1;
            s_q.sync_prev <= 1'b1;
            s_q.rx_state  <= RX_HUNT;
            s_q.rx_shift  <= SHIFT_ONES;
            s_q.tx_line   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata                 = s_q.rdata;
    assign o_serial_out            = s_q.tx_line;
    assign o_receive_done_request  = s_q.rx_req;
    assign o_transmit_done_request = s_q.tx_req;
    assign o_timer_irq             = s_q.timer_irq;

    // ==========================================================
    // Assertions
    AST_IDLE_MARK: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        !s_q.tx_busy |-> o_serial_out)
        else $error("line not marking while idle");
    AST_WRITE_START: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (wr_data && serial_on) |=> (!o_serial_out && s_q.tx_tick == TICK_ZERO))
        else $error("write did not start frame");
    AST_TX_DONE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $fell(s_q.tx_busy) && serial_on |-> o_transmit_done_request)
        else $error("no transmit done request");
    AST_RX_DONE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(o_receive_done_request) |-> s_q.rx_state == RX_HUNT &&
        s_q.rx_shift == SHIFT_ONES)
        else $error("receiver not rearmed");
    AST_FALSE_START: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (s_q.rx_state == RX_START && tick &&
         s_q.rx_tick == TICK_MID - TICK_ONE && s_q.sync2)
        |=> s_q.rx_state == RX_HUNT)
        else $error("false start not rejected");
    AST_HUNT_ONES: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        s_q.rx_state == RX_HUNT |-> s_q.rx_shift == SHIFT_ONES)
        else $error("shifter not all ones while hunting");
    AST_NO_TIMER_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        serial_on |=> !o_timer_irq || !$past(serial_on))
        else $error("timer interrupt in serial mode");
    AST_RX_READ: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        (i_rd && i_addr == ADDR_DATA_BUFFER) |=> o_rdata == $past(s_q.rx_buf))
        else $error("read did not return receive buffer");

    // Shift clock events, named once so the checks below stay readable
    logic rx_last;
    logic tx_last;
    assign rx_last = s_q.rx_state == RX_DATA && tick &&
                     s_q.rx_tick == TICK_LAST &&
                     s_q.rx_cnt == RX_DATA_BITS - CNT_ONE;
    assign tx_last = s_q.tx_busy && tick && s_q.tx_tick == TICK_LAST &&
                     s_q.tx_cnt == TX_FRAME_BITS;

    AST_SYNC_FIRST: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) $past(i_resetn) |->
        s_q.sync1 == $past(i_serial_input_pin))
        else $error("first sync stage lost the pin");

    AST_SYNC_SECOND: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) $past(i_resetn) |->
        s_q.sync2 == $past(s_q.sync1))
        else $error("second sync stage skipped");

    AST_START_ARM: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (s_q.rx_state == RX_HUNT && serial_on &&
        s_q.sync_prev && !s_q.sync2) |=> (s_q.rx_state == RX_START &&
        s_q.rx_tick == TICK_ZERO) || !serial_on)
        else $error("falling edge did not arm receiver");

    AST_MID_START: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (s_q.rx_state == RX_START && tick &&
        s_q.rx_tick == TICK_MID - TICK_ONE && !s_q.sync2) |=>
        s_q.rx_state == RX_DATA || !serial_on)
        else $error("valid start bit not accepted");

    AST_START_BOUND: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn)
        s_q.rx_state == RX_START |-> s_q.rx_tick < TICK_MID)
        else $error("start count passed mid bit");

    AST_DATA_SHIFT: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (s_q.rx_state == RX_DATA && tick &&
        s_q.rx_tick == TICK_LAST && !rx_last) |=>
        s_q.rx_shift == {$past(s_q.sync2), $past(s_q.rx_shift[7:1])} ||
        !serial_on)
        else $error("receive bit not shifted");

    AST_DATA_IDLE: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (s_q.rx_state == RX_DATA && !tick) |=>
        s_q.rx_tick == $past(s_q.rx_tick))
        else $error("receive divider moved without pulse");

    AST_RX_COUNT: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn)
        s_q.rx_state == RX_DATA |-> s_q.rx_cnt < RX_DATA_BITS)
        else $error("receive bit count overflow");

    AST_RX_DELIVER: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) rx_last |=> o_receive_done_request &&
        s_q.rx_buf == $past(rx_char))
        else $error("character not delivered");

    AST_PARITY_FLAG: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (rx_last && parity_on) |=>
        s_q.rx_buf[DATA_MSB] ==
        ~^{$past(s_q.sync2), $past(s_q.rx_shift[7:1])})
        else $error("parity flag wrong");

    AST_NO_PARITY: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (rx_last && !parity_on) |=>
        s_q.rx_buf[DATA_MSB] == $past(s_q.sync2))
        else $error("bit 7 altered without parity");

    AST_TX_PARITY: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (wr_data && serial_on && parity_on) |=>
        ^s_q.tx_shift[DATA_MSB:0] == 1'b1)
        else $error("transmit parity not odd");

    AST_TX_STOPS: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (wr_data && serial_on) |=>
        s_q.tx_shift[10:8] == 3'h7 && s_q.tx_cnt == CNT_ONE)
        else $error("frame not loaded with stops");

    AST_TX_BIT: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (s_q.tx_busy && tick &&
        s_q.tx_tick == TICK_LAST && !tx_last && !wr_data) |=>
        o_serial_out == $past(s_q.tx_shift[0]) || !serial_on)
        else $error("wrong bit on line");

    AST_TX_HOLD: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (s_q.tx_busy && !tick && !wr_data) |=>
        $stable(o_serial_out) || !serial_on)
        else $error("line moved between shift clocks");

    AST_TX_DONE_CNT: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) $rose(o_transmit_done_request) |->
        $past(s_q.tx_cnt) == TX_FRAME_BITS)
        else $error("transmit done before second stop");

    AST_TIMER_IRQ: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (!serial_on && i_timer_tick) |=>
        o_timer_irq)
        else $error("timer interrupt missing");

    AST_REQ_CLEAR: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (i_wr && i_addr == ADDR_REQUESTS &&
        i_wdata[REQ_TX_BIT] && !tx_last) |=> !o_transmit_done_request)
        else $error("transmit request not cleared");

    AST_READ_IDLE: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) !i_rd |=> o_rdata == DATA_RESET)
        else $error("read data without read");

    AST_MODE_WRITE: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (i_wr && i_addr == ADDR_PORT3_MODE) |=>
        s_q.mode == $past(i_wdata))
        else $error("mode write lost");

    AST_OFF_MARK: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) !serial_on |=> o_serial_out)
        else $error("line not marking with serial off");

    AST_HUNT_STOP: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn)
        s_q.rx_state == RX_HUNT |=> s_q.rx_state != RX_DATA)
        else $error("shifting without start bit");

    AST_PINS_READ: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (i_rd && i_addr == ADDR_PORT3_PINS) |=>
        o_rdata[0] == $past(s_q.sync2))
        else $error("serial pin not readable");
endmodule : ast_uart

// File: ast_remote.sv
`timescale 1ns/1ns
// ==========================================================
// Remote serial transceiver on the far end of the line
module ast_remote #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic i_clk_sys,
    input  wire logic i_line,
    output logic      o_line
);
    logic [7:0] rx_byte;
    int         rx_cnt;

    // Line idles marking, as an idle serial line does
    initial begin
        o_line  = 1'b1;
        rx_byte = 8'h00;
        rx_cnt  = 0;
    end

    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BIT_CLKS) @(posedge i_clk_sys);
        end
    endtask : send

    // Low pulse of two ticks, too short to be a start bit
    task automatic glitch();
        o_line <= 1'b0;
        repeat (BIT_CLKS / 8) @(posedge i_clk_sys);
        o_line <= 1'b1;
        repeat (BIT_CLKS) @(posedge i_clk_sys);
    endtask : glitch

    // Sample mid-bit; resyncs on the next falling edge only
    always begin
        @(negedge i_line);
        repeat (BIT_CLKS / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 9; i++) begin
            if (i > 0) rx_byte[i-1] = i_line;
            repeat (BIT_CLKS) @(posedge i_clk_sys);
        end
        rx_cnt++;
    end
endmodule : ast_remote

// File: ast_uart_tb.sv
`timescale 1ns/1ns
// ==========================================================
// Bench for the serial transceiver
module ast_uart_tb;
    import ast_pkg::*;
    logic       clk_sys = 0, resetn = 0, wr = 0, rd = 0, tick = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
    logic       ser_out, rx_req, tx_req, t_irq, line_in;
    int         error_cnt = 0, checked = 0, cycles = 0, div = 0;

    always #2 clk_sys = ~clk_sys;
    // Timer pulse every fourth clock: one bit is 64 clocks
    always @(posedge clk_sys) begin
        div  <= (div + 1) % 4;
        tick <= (div == 3);
    end
    // A hang costs a mismatch and closes the run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            stop_test();
        end
    end

    ast_uart i_ast_uart (.i_clk_sys(clk_sys), .i_resetn(resetn),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_timer_tick(tick),
        .i_serial_input_pin(line_in), .o_serial_out(ser_out),
        .o_receive_done_request(rx_req),
        .o_transmit_done_request(tx_req), .o_timer_irq(t_irq));
    ast_remote i_ast_remote (.i_clk_sys(clk_sys), .i_line(ser_out),
        .o_line(line_in));

    // ======================================================
    // Shared tasks
    task automatic check(string n, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    endtask : wreg
    task automatic rreg(logic [7:0] a);
        @(posedge clk_sys);
        addr <= a; rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rreg
    task automatic wait_cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    // Counts timer interrupt pulses over 16 clocks
    task automatic irq_cnt(logic [7:0] e);
        int n = 0;
        repeat (16) begin
            @(posedge clk_sys);
            #1 n += int'(t_irq === 1'b1);
        end
        check("timer_irq", 8'(n), e);
    endtask : irq_cnt
    task automatic wait_tx();
        int n = 0;
        while (tx_req !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        #1 check("tx_req", {7'h0, tx_req}, 8'h01);
    endtask : wait_tx

    // ======================================================
    // Scenarios
    task automatic t_reset();
        check("line", {7'h0, ser_out}, 8'h01);
        check("reqs", {6'h0, tx_req, rx_req}, 8'h00);
        rreg(ADDR_PORT3_MODE); check("mode", v, 8'h00);
        rreg(ADDR_PORT3_PINS); check("pins", v, 8'h81);
        rreg(8'h10); check("unmapped", v, 8'h00);
        irq_cnt(8'h04);
    endtask : t_reset
    task automatic t_tx(logic [7:0] m, logic [7:0] d, logic [7:0] e);
        wreg(ADDR_PORT3_MODE, m);
        wreg(ADDR_REQUESTS, 8'h03);
        wreg(ADDR_DATA_BUFFER, d);
        check("start", {7'h0, ser_out}, 8'h00);
        irq_cnt(8'h00);
        wait_tx();
        check("tx_byte", i_ast_remote.rx_byte, e);
        check("mark", {7'h0, ser_out}, 8'h01);
    endtask : t_tx
    task automatic t_rx(logic [7:0] m, logic [7:0] d, logic [7:0] e);
        wreg(ADDR_PORT3_MODE, m);
        wreg(ADDR_REQUESTS, 8'h03);
        i_ast_remote.send(d);
        #1 check("rx_req", {7'h0, rx_req}, 8'h01);
        rreg(ADDR_DATA_BUFFER); check("rx_byte", v, e);
    endtask : t_rx
    task automatic t_over();
        wreg(ADDR_REQUESTS, 8'h03);
        i_ast_remote.send(8'h11);
        i_ast_remote.send(8'h22);
        rreg(ADDR_DATA_BUFFER); check("over", v, 8'h22);
        wreg(ADDR_REQUESTS, 8'h03);
        rreg(ADDR_REQUESTS); check("clr", v, 8'h00);
        i_ast_remote.glitch();
        wait_cyc(640);
        check("false", {7'h0, rx_req}, 8'h00);
        t_rx(8'h40, 8'h5A, 8'h5A);
    endtask : t_over
    task automatic t_break();
        wreg(ADDR_REQUESTS, 8'h03);
        wreg(ADDR_DATA_BUFFER, 8'hFF);
        wait_cyc(300);
        wreg(ADDR_DATA_BUFFER, 8'h01);
        check("restart", {7'h0, ser_out}, 8'h00);
        wait_cyc(56); check("st", {7'h0, ser_out}, 8'h00);
        wait_cyc(16); check("b0", {7'h0, ser_out}, 8'h01);
        wait_cyc(380); check("old", {7'h0, tx_req}, 8'h00);
        wait_tx();
    endtask : t_break

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // Main sequence: reset held for ten clocks
    initial begin
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 t_reset();
        t_tx(8'h40, 8'hA5, 8'hA5);
        t_tx(8'hC0, 8'h03, 8'h83);
        t_tx(8'hC0, 8'h07, 8'h07);
        t_rx(8'h40, 8'h3C, 8'h3C);
        t_rx(8'hC0, 8'h80, 8'h00);
        t_rx(8'hC0, 8'h81, 8'h81);
        wreg(ADDR_PORT3_MODE, 8'h40);
        t_over();
        t_break();
        stop_test();
    end
endmodule : ast_uart_tb
